// ==== option_trim_flash_timing_cfg.sv ====
// option_trim_flash_timing_cfg: flash timing value, option byte latches, trim registers
// assumes program memory answers a read with data in the same cycle the strobe is up
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

module option_trim_flash_timing_cfg
	import option_trim_pkg::*;
(
	// clock and reset
	input  wire logic        MCLK_IN,
	input  wire logic        RSTN_IN,
	// register port
	input  wire logic [11:0] REG_ADDR_IN,
	input  wire logic [7:0]  REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [7:0]  REG_RDATA_OUT,
	// program memory and information area read port
	output logic      [15:0] MEM_ADDR_OUT,
	output logic             MEM_RD_OUT,
	output logic             MEM_INFO_OUT,
	input  wire logic [7:0]  MEM_RDATA_IN,
	// load status
	output logic             LOAD_BUSY_OUT,
	// flash timing
	output logic      [15:0] FLASH_TIMING_VALUE_OUT,
	// active configuration
	output logic             WATCHDOG_TIMEOUT_ACTION_OUT,
	output logic             WATCHDOG_AUTO_ENABLE_OUT,
	output logic      [1:0]  CRYSTAL_DRIVE_SELECT_OUT,
	output logic             BROWNOUT_KEEP_ON_OUT,
	output logic             CODE_READOUT_BLOCK_OUT,
	output logic             FLASH_MODIFY_GUARD_OUT,
	output logic      [7:0]  OPTION_BYTE1_OUT
);

	typedef struct packed {
		load_state_type    state;
		logic              pending;
		logic [4:0]        load_idx;
		logic [7:0]        timing_high;
		logic [7:0]        timing_low;
		logic [7:0]        trim_addr;
		logic [7:0]        option0;
		logic [7:0]        option1;
		option_fields_type fields;
		logic [7:0]        rdata;
		mem_req_type       mem;
		logic              mem_info;
	} state_type;

	state_type   s_reg;
	state_type   s_next;
	reg_req_type req;
	logic        trim_wr;
	logic [4:0]  trim_wr_idx;
	logic [7:0]  trim_wr_data;
	logic [7:0]  trim_rd_data;
	logic        trim_in_range;

	assign req.addr  = REG_ADDR_IN;
	assign req.wdata = REG_WDATA_IN;
	assign req.wr    = REG_WR_IN;
	assign req.rd    = REG_RD_IN;

	assign trim_in_range = (s_reg.trim_addr[7:5] == 3'b000);

	trim_store #(
		.DEPTH (TRIM_COUNT),
		.IDX_W (TRIM_IDX_W)
	) u_trim_store (
		.clk_in      (MCLK_IN),
		.wr_in       (trim_wr),
		.wr_idx_in   (trim_wr_idx),
		.wr_data_in  (trim_wr_data),
		.rd_idx_in   (s_reg.trim_addr[4:0]),
		.rd_data_out (trim_rd_data)
	);

	// trim write mux: loader while loading, software afterwards
	always_comb
	begin
		trim_wr      = 1'b0;
		trim_wr_idx  = s_reg.load_idx;
		trim_wr_data = MEM_RDATA_IN;
		if (s_reg.state == LOAD_TRIM && s_reg.pending)
		begin
			trim_wr = 1'b1;
		end
		else if (s_reg.state == LOAD_DONE && req.wr && req.addr == TRIM_DATA_OFS
				&& trim_in_range)
		begin
			trim_wr      = 1'b1;
			trim_wr_idx  = s_reg.trim_addr[4:0];
			trim_wr_data = req.wdata;
		end
	end

	always_comb
	begin
		s_next         = s_reg;
		s_next.mem.rd  = 1'b0;
		s_next.pending = 1'b0;
		s_next.rdata   = BYTE_ZERO;
		if (!RSTN_IN)
		begin
			s_next.state       = LOAD_OPT0;
			s_next.load_idx    = IDX_ZERO;
			s_next.timing_high = BYTE_ZERO;
			s_next.timing_low  = BYTE_ZERO;
			s_next.trim_addr   = BYTE_ZERO;
			s_next.option0     = ERASED_BYTE;
			s_next.option1     = ERASED_BYTE;
			s_next.fields      = '1;
			s_next.mem.addr    = OPTION0_MEM_ADDR;
			s_next.mem_info    = 1'b0;
		end
		else
		begin
			case (s_reg.state)
				LOAD_OPT0:
				begin
					// option byte zero is fetched first
					if (s_reg.pending)
					begin
						s_next.option0  = MEM_RDATA_IN;
						s_next.state    = LOAD_OPT1;
						s_next.mem.addr = OPTION1_MEM_ADDR;
						s_next.mem.rd   = 1'b1;
						s_next.pending  = 1'b1;
					end
					else
					begin
						s_next.mem.addr = OPTION0_MEM_ADDR;
						s_next.mem.rd   = 1'b1;
						s_next.pending  = 1'b1;
					end
				end
				LOAD_OPT1:
				begin
					if (s_reg.pending)
					begin
						s_next.option1  = MEM_RDATA_IN;
						s_next.state    = LOAD_TRIM;
						s_next.load_idx = IDX_ZERO;
						s_next.mem.addr = TRIM_INFO_BASE;
						s_next.mem_info = 1'b1;
						s_next.mem.rd   = 1'b1;
						s_next.pending  = 1'b1;
					end
				end
				LOAD_TRIM:
				begin
					if (s_reg.pending)
					begin
						if (s_reg.load_idx == IDX_LAST)
						begin
							s_next.state    = LOAD_DONE;
							s_next.mem_info = 1'b0;
							// latch fields once, held until next reset
							s_next.fields.watchdog_timeout_action = s_reg.option0[WDT_ACTION_BIT];
							s_next.fields.watchdog_auto_enable = s_reg.option0[WDT_AUTO_BIT];
							s_next.fields.crystal_drive_select =
								s_reg.option0[XTAL_HI_BIT:XTAL_LO_BIT];
							s_next.fields.brownout_keep_on = s_reg.option0[BROWNOUT_BIT];
							s_next.fields.code_readout_block = s_reg.option0[READOUT_BIT];
							s_next.fields.flash_modify_guard = s_reg.option0[MODIFY_BIT];
						end
						else
						begin
							s_next.load_idx = s_reg.load_idx + 5'h01;
							s_next.mem.addr = s_reg.mem.addr + 16'h0001;
							s_next.mem.rd   = 1'b1;
							s_next.pending  = 1'b1;
						end
					end
				end
				LOAD_DONE:
				begin
					// no path back to loading except reset
					if (req.wr)
					begin
						if (req.addr == FREQ_HIGH_OFS)
						begin
							s_next.timing_high = req.wdata;
						end
						else if (req.addr == FREQ_LOW_OFS)
						begin
							s_next.timing_low = req.wdata;
						end
						else if (req.addr == TRIM_ADDR_OFS)
						begin
							s_next.trim_addr = req.wdata;
						end
					end
				end
				default:
				begin
					s_next.state = LOAD_OPT0;
				end
			endcase
			if (req.rd)
			begin
				if (req.addr == FREQ_HIGH_OFS)
				begin
					s_next.rdata = s_reg.timing_high;
				end
				else if (req.addr == FREQ_LOW_OFS)
				begin
					s_next.rdata = s_reg.timing_low;
				end
				else if (req.addr == TRIM_ADDR_OFS)
				begin
					s_next.rdata = s_reg.trim_addr;
				end
				else if (req.addr == TRIM_DATA_OFS && trim_in_range)
				begin
					s_next.rdata = trim_rd_data;
				end
				else if (req.addr == OPTION0_OFS)
				begin
					s_next.rdata = s_reg.option0;
				end
				else if (req.addr == OPTION1_OFS)
				begin
					s_next.rdata = s_reg.option1;
				end
				else if (req.addr == LOAD_STATUS_OFS)
				begin
					s_next.rdata = {7'b000_0000, (s_reg.state != LOAD_DONE)};
				end
			end
		end
	end

	always_ff @(posedge MCLK_IN)
	begin
		s_reg <= s_next;
	end

	assign REG_RDATA_OUT               = s_reg.rdata;
	assign MEM_ADDR_OUT                = s_reg.mem.addr;
	assign MEM_RD_OUT                  = s_reg.mem.rd;
	assign MEM_INFO_OUT                = s_reg.mem_info;
	assign LOAD_BUSY_OUT               = (s_reg.state != LOAD_DONE);
	assign FLASH_TIMING_VALUE_OUT      = {s_reg.timing_high, s_reg.timing_low};
	assign WATCHDOG_TIMEOUT_ACTION_OUT = s_reg.fields.watchdog_timeout_action;
	assign WATCHDOG_AUTO_ENABLE_OUT    = s_reg.fields.watchdog_auto_enable;
	assign CRYSTAL_DRIVE_SELECT_OUT    = s_reg.fields.crystal_drive_select;
	assign BROWNOUT_KEEP_ON_OUT        = s_reg.fields.brownout_keep_on;
	assign CODE_READOUT_BLOCK_OUT      = s_reg.fields.code_readout_block;
	assign FLASH_MODIFY_GUARD_OUT      = s_reg.fields.flash_modify_guard;
	assign OPTION_BYTE1_OUT            = s_reg.option1;

endmodule : option_trim_flash_timing_cfg

// ==== option_trim_pkg.sv ====
// option_trim_pkg: register map, field positions, reset values and states
// assumes one system clock and a synchronous active-low reset
package option_trim_pkg;

	localparam int          ADDR_W           = 12;
	localparam int          DATA_W           = 8;
	localparam int          TRIM_COUNT       = 32;
	localparam int          TRIM_IDX_W       = 5;

	// register offsets
	localparam logic [11:0] TRIM_ADDR_OFS    = 12'h0ff6;
	localparam logic [11:0] TRIM_DATA_OFS    = 12'h0ff7;
	localparam logic [11:0] FREQ_HIGH_OFS    = 12'h0ffa;
	localparam logic [11:0] FREQ_LOW_OFS     = 12'h0ffb;
	localparam logic [11:0] OPTION0_OFS      = 12'h0ff0;
	localparam logic [11:0] OPTION1_OFS      = 12'h0ff1;
	localparam logic [11:0] LOAD_STATUS_OFS  = 12'h0ff2;

	// program memory and information area addresses
	localparam logic [15:0] OPTION0_MEM_ADDR = 16'h0000;
	localparam logic [15:0] OPTION1_MEM_ADDR = 16'h0001;
	localparam logic [15:0] TRIM_INFO_BASE   = 16'h0020;

	// option byte zero field positions
	localparam int          WDT_ACTION_BIT   = 7;
	localparam int          WDT_AUTO_BIT     = 6;
	localparam int          XTAL_HI_BIT      = 5;
	localparam int          XTAL_LO_BIT      = 4;
	localparam int          BROWNOUT_BIT     = 3;
	localparam int          READOUT_BIT      = 2;
	localparam int          MODIFY_BIT       = 0;

	// reset values and loader index bounds
	localparam logic [7:0]  BYTE_ZERO        = 8'h00;
	localparam logic [7:0]  ERASED_BYTE      = 8'hff;
	localparam logic [15:0] TIMING_RESET     = 16'h0000;
	localparam logic [4:0]  IDX_ZERO         = 5'h00;
	localparam logic [4:0]  IDX_LAST         = 5'h1f;

	typedef enum logic [2:0] {
		LOAD_OPT0,
		LOAD_OPT1,
		LOAD_TRIM,
		LOAD_DONE
	} load_state_type;

	typedef struct packed {
		logic       watchdog_timeout_action;
		logic       watchdog_auto_enable;
		logic [1:0] crystal_drive_select;
		logic       brownout_keep_on;
		logic       code_readout_block;
		logic       flash_modify_guard;
	} option_fields_type;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_type;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
	} mem_req_type;

endpackage : option_trim_pkg

// ==== option_trim_sva.sv ====
// option_trim_sva: port checks for the configuration block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module option_trim_sva
	import option_trim_pkg::*;
(
	// clock and reset
	input wire logic        MCLK_IN,
	input wire logic        RSTN_IN,
	// register port
	input wire logic [11:0] REG_ADDR_IN,
	input wire logic [7:0]  REG_WDATA_IN,
	input wire logic        REG_WR_IN,
	input wire logic        REG_RD_IN,
	input wire logic [7:0]  REG_RDATA_OUT,
	// loader and outputs
	input wire logic [15:0] MEM_ADDR_OUT,
	input wire logic        MEM_RD_OUT,
	input wire logic        MEM_INFO_OUT,
	input wire logic        LOAD_BUSY_OUT,
	input wire logic [15:0] FLASH_TIMING_VALUE_OUT,
	input wire logic [1:0]  CRYSTAL_DRIVE_SELECT_OUT,
	input wire logic [7:0]  OPTION_BYTE1_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);
	logic wr_ok;
	assign wr_ok = REG_WR_IN && !LOAD_BUSY_OUT;
	chk_rdata_idle: assert property (
		!$past(REG_RD_IN) |-> REG_RDATA_OUT == BYTE_ZERO) else $error("read data not idle");
	chk_timing_high: assert property (
		wr_ok && REG_ADDR_IN == FREQ_HIGH_OFS |=> FLASH_TIMING_VALUE_OUT[15:8] ==
		$past(REG_WDATA_IN)) else $error("timing high byte wrong");
	chk_timing_low: assert property (
		wr_ok && REG_ADDR_IN == FREQ_LOW_OFS |=> FLASH_TIMING_VALUE_OUT[7:0] ==
		$past(REG_WDATA_IN)) else $error("timing low byte wrong");
	chk_timing_hold: assert property (
		!(REG_WR_IN && REG_ADDR_IN[11:1] == FREQ_HIGH_OFS[11:1])
		|=> $stable(FLASH_TIMING_VALUE_OUT)) else $error("timing changed unasked");
	chk_timing_read: assert property (
		REG_RD_IN && REG_ADDR_IN == FREQ_LOW_OFS |=> REG_RDATA_OUT ==
		FLASH_TIMING_VALUE_OUT[7:0]) else $error("timing readback wrong");
	chk_option_hold: assert property (
		!LOAD_BUSY_OUT |=> $stable(CRYSTAL_DRIVE_SELECT_OUT) && $stable(OPTION_BYTE1_OUT))
		else $error("options changed after load");
	chk_mem_quiet: assert property (
		!LOAD_BUSY_OUT && !$past(LOAD_BUSY_OUT) |-> !MEM_RD_OUT) else $error("late memory read");
	chk_first_read: assert property (
		$rose(RSTN_IN) |=> MEM_RD_OUT && MEM_ADDR_OUT == OPTION0_MEM_ADDR && !MEM_INFO_OUT)
		else $error("first fetch wrong");
	chk_load_bound: assert property (
		$rose(RSTN_IN) |-> ##[1:80] !LOAD_BUSY_OUT) else $error("load too long");
	chk_mem_area: assert property (
		MEM_RD_OUT |-> (MEM_INFO_OUT ? (MEM_ADDR_OUT - TRIM_INFO_BASE) < 16'h0020 :
		MEM_ADDR_OUT <= OPTION1_MEM_ADDR)) else $error("fetch address wrong");
	cover property ($fell(LOAD_BUSY_OUT));
	cover property (wr_ok && REG_ADDR_IN == FREQ_HIGH_OFS);
	cover property (wr_ok && REG_ADDR_IN == TRIM_DATA_OFS);
endmodule : option_trim_sva
bind option_trim_flash_timing_cfg option_trim_sva chk_i (
	.MCLK_IN, .RSTN_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT,
	.MEM_ADDR_OUT, .MEM_RD_OUT, .MEM_INFO_OUT, .LOAD_BUSY_OUT, .FLASH_TIMING_VALUE_OUT,
	.CRYSTAL_DRIVE_SELECT_OUT, .OPTION_BYTE1_OUT
);

// ==== tb_top.sv ====
// tb_top: self-checking bench for the option and trim block
// assumes the bench plays software and program memory
`timescale 1ns/1ps
module tb_top
	import option_trim_pkg::*;
;
	// design ports
	logic        MCLK_IN = 1'b0, RSTN_IN = 1'b0, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0;
	logic [11:0] REG_ADDR_IN = 12'h0000;
	logic [7:0]  REG_WDATA_IN = 8'h00, MEM_RDATA_IN = 8'h00, REG_RDATA_OUT, OPTION_BYTE1_OUT;
	logic [15:0] MEM_ADDR_OUT, FLASH_TIMING_VALUE_OUT;
	logic [1:0]  CRYSTAL_DRIVE_SELECT_OUT;
	logic        MEM_RD_OUT, MEM_INFO_OUT, LOAD_BUSY_OUT, WATCHDOG_TIMEOUT_ACTION_OUT;
	logic        WATCHDOG_AUTO_ENABLE_OUT, BROWNOUT_KEEP_ON_OUT, CODE_READOUT_BLOCK_OUT;
	logic        FLASH_MODIFY_GUARD_OUT;
	// bench model
	int          err_total = 0, samples_checked = 0, seed = 32'h405e;
	logic [7:0]  mem0, mem1, act0, act1, d, h, l;
	logic [7:0]  fac [TRIM_COUNT];
	logic [7:0]  work [TRIM_COUNT];
	option_trim_flash_timing_cfg uut (
		.MCLK_IN, .RSTN_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN,
		.REG_RDATA_OUT, .MEM_ADDR_OUT, .MEM_RD_OUT, .MEM_INFO_OUT, .MEM_RDATA_IN,
		.LOAD_BUSY_OUT, .FLASH_TIMING_VALUE_OUT, .WATCHDOG_TIMEOUT_ACTION_OUT,
		.WATCHDOG_AUTO_ENABLE_OUT, .CRYSTAL_DRIVE_SELECT_OUT, .BROWNOUT_KEEP_ON_OUT,
		.CODE_READOUT_BLOCK_OUT, .FLASH_MODIFY_GUARD_OUT, .OPTION_BYTE1_OUT
	);
	always #10 MCLK_IN = ~MCLK_IN;
	// program memory data stand while the fetch strobe is up, so the loader takes them
	// at the edge after the strobe rose; junk otherwise
	always @*
		if (MEM_RD_OUT)
			MEM_RDATA_IN = MEM_INFO_OUT ? fac[MEM_ADDR_OUT[4:0]] : (MEM_ADDR_OUT[0] ? mem1 : mem0);
		else
			MEM_RDATA_IN = ~MEM_ADDR_OUT[7:0];
	task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge MCLK_IN);
		REG_ADDR_IN  <= a;
		REG_WDATA_IN <= v;
		REG_WR_IN    <= 1'b1;
		@(posedge MCLK_IN);
		REG_WR_IN    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge MCLK_IN);
		REG_ADDR_IN <= a;
		REG_RD_IN   <= 1'b1;
		@(posedge MCLK_IN);
		REG_RD_IN   <= 1'b0;
		#1 v = REG_RDATA_OUT;
	endtask : rd
	task automatic fields;
		chk("wdt action", WATCHDOG_TIMEOUT_ACTION_OUT, act0[WDT_ACTION_BIT]);
		chk("wdt auto", WATCHDOG_AUTO_ENABLE_OUT, act0[WDT_AUTO_BIT]);
		chk("xtal", CRYSTAL_DRIVE_SELECT_OUT, act0[XTAL_HI_BIT:XTAL_LO_BIT]);
		chk("brownout", BROWNOUT_KEEP_ON_OUT, act0[BROWNOUT_BIT]);
		chk("readout", CODE_READOUT_BLOCK_OUT, act0[READOUT_BIT]);
		chk("modify", FLASH_MODIFY_GUARD_OUT, act0[MODIFY_BIT]);
		chk("option1", OPTION_BYTE1_OUT, act1);
	endtask : fields
	task automatic boot(input logic [7:0] o0);
		int n;
		mem0 = o0;
		mem1 = 8'($random(seed));
		RSTN_IN <= 1'b0;
		repeat (16) @(posedge MCLK_IN);
		RSTN_IN <= 1'b1;
		wr(FREQ_HIGH_OFS, 8'ha5);
		for (n = 0; n < 200 && LOAD_BUSY_OUT !== 1'b0; n++)
			@(posedge MCLK_IN);
		act0 = mem0;
		act1 = mem1;
		chk("load time", 16'(n < 100), 16'h0001);
		chk("timing", FLASH_TIMING_VALUE_OUT, TIMING_RESET);
		fields();
		rd(OPTION0_OFS, d);
		chk("option0 reg", d, act0);
		for (n = 0; n < TRIM_COUNT; n++)
		begin
			wr(TRIM_ADDR_OFS, 8'(n));
			rd(TRIM_DATA_OFS, d);
			chk("trim reload", d, fac[n]);
		end
		$display("boot %h done", o0);
	endtask : boot
	task automatic stop_test;
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	initial
	begin
		#400000;
		err_total++;
		stop_test();
	end
	initial
	begin
		foreach (fac[i])
			fac[i] = 8'($random(seed));
		boot(8'($random(seed)) | 8'h02);
		for (int k = 0; k < 4; k++)
		begin
			h = 8'($random(seed));
			l = 8'($random(seed));
			wr(FREQ_HIGH_OFS, h);
			wr(FREQ_LOW_OFS, l);
			#1;
			chk("timing", FLASH_TIMING_VALUE_OUT, {h, l});
			rd(FREQ_HIGH_OFS, d);
			chk("timing high", d, h);
		end
		// software loads the clock in kHz, here 20 MHz, the top of the flash range
		wr(FREQ_HIGH_OFS, 8'h4e);
		wr(FREQ_LOW_OFS, 8'h20);
		#1;
		chk("timing khz", FLASH_TIMING_VALUE_OUT, 16'h4e20);
		$display("timing done");
		foreach (work[n])
		begin
			work[n] = 8'($random(seed));
			wr(TRIM_ADDR_OFS, 8'(n));
			wr(TRIM_DATA_OFS, work[n]);
		end
		wr(TRIM_ADDR_OFS, 8'h20);
		wr(TRIM_DATA_OFS, 8'h5a);
		rd(TRIM_DATA_OFS, d);
		chk("trim out of range", d, BYTE_ZERO);
		foreach (work[n])
		begin
			wr(TRIM_ADDR_OFS, 8'(n));
			rd(TRIM_DATA_OFS, d);
			chk("trim working", d, work[n]);
		end
		rd(12'h0ff3, d);
		chk("unmapped", d, BYTE_ZERO);
		wr(OPTION0_OFS, ~act0);
		rd(OPTION0_OFS, d);
		chk("option0 ro", d, act0);
		$display("trims done");
		mem0 = ERASED_BYTE;
		mem1 = ERASED_BYTE;
		repeat (10) @(posedge MCLK_IN);
		fields();
		boot(ERASED_BYTE);
		for (int c = 0; c < 4; c++)
			boot((8'($random(seed)) & 8'hcf) | 8'(c << 4) | 8'h02);
		stop_test();
	end
endmodule : tb_top

// ==== trim_store.sv ====
// trim_store: working copy of the trim values, one write and one read port
// assumes writes come from the loader or software, never both in one cycle
`timescale 1ns/1ps
module trim_store
	import option_trim_pkg::*;
#(
	parameter int DEPTH = TRIM_COUNT,
	parameter int IDX_W = TRIM_IDX_W
)(
	// clock
	input  wire logic             clk_in,
	// write port
	input  wire logic             wr_in,
	input  wire logic [IDX_W-1:0] wr_idx_in,
	input  wire logic [7:0]       wr_data_in,
	// read port
	input  wire logic [IDX_W-1:0] rd_idx_in,
	output logic      [7:0]       rd_data_out
);

	logic [7:0] mem_reg [DEPTH];

	always_ff @(posedge clk_in)
	begin
		if (wr_in)
		begin
			mem_reg[wr_idx_in] <= wr_data_in;
		end
	end

	assign rd_data_out = mem_reg[rd_idx_in];

endmodule : trim_store
